// >>> src/fault_interrupt_and_reset_logic.sv
// Purpose: Fault, thermal monitor, interrupt and register reset logic
// Assumes: Comparator results arrive synchronous to clk_i
// Notes:   Register port is a simple read/write strobe port behind the
//          serial interface; reads of interrupt groups clear them.
// Contract
// R1: Stay dormant after undervoltage until rising threshold
// R2: Host keeps falling threshold below rising threshold
// R3: Power-on reset kills logic supply, resets registers
// R4: Two thermal warning events at two thresholds
// R5: Thermal shutdown disables outputs, resets buck config
// R6: Monitor active on enable, force bit, or hysteresis
// R7: Open-drain active-low interrupt is NOR of unmasked
// R8: Host reads source register first, then groups
// R9: Reading a group clears its source flag
// R10: Interrupt bits set only on condition edges
// R11: Whole group read at once, cleared on read
// R12: Release line when clear; new events keep it low
// R13: Line stays low until cleared or masked
// R14: Reset masks everything except undervoltage
// R15: Mode zero sets bits, mask gates summary
// R16: Mode one blocks masked events at the bit
// R17: Shutdown with all enables low resets registers
// R18: Load resistor defaults on enable, hold them
// R19: Below falling threshold disable outputs, reset config
// R20: Logic supply on while any enable high
// R21: Summary holds one flag per group
`timescale 1ns/10ps
`default_nettype none
module fault_interrupt_and_reset_logic #(
  parameter int NUM_OUT = 2
) (
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic                ce_i,
  // Supply and thermal comparators
  input  wire logic                sys_above_rise_i,
  input  wire logic                sys_below_fall_i,
  input  wire logic                sys_below_por_i,
  input  wire logic                temp_above_warn1_i,
  input  wire logic                temp_above_warn2_i,
  input  wire logic                temp_at_or_below_hyst_i,
  input  wire logic                thermal_shutdown_i,
  input  wire logic [NUM_OUT-1:0]  buck_fault_i,
  // Enable pins
  input  wire logic                serial_enable_pin_i,
  input  wire logic [NUM_OUT-1:0]  output_enable_pin_i,
  input  wire logic [NUM_OUT-1:0]  output_enable_bit_i,
  // Resistor detection results
  input  wire logic [7:0]          det_voltage_code_i,
  input  wire logic [1:0]          det_range_i,
  input  wire logic [1:0]          det_ilim_i,
  input  wire logic [1:0]          det_freq_i,
  // Register port
  input  wire logic                reg_rd_i,
  input  wire logic                reg_wr_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  output logic      [7:0]          reg_rdata_o,
  // Outputs
  output logic                     logic_supply_en_o,
  output logic                     serial_if_en_o,
  output logic [NUM_OUT-1:0]       regulator_on_o,
  output logic                     thermal_monitor_on_o,
  output logic                     config_reset_o,
  output logic [7:0]               target_voltage_code_o,
  output logic [1:0]               voltage_range_sel_o,
  output logic [1:0]               peak_current_limit_sel_o,
  output logic [1:0]               switch_freq_sel_o,
  output logic                     irq_out_n_o,
  output logic                     irq_out_n_oe_o
);
  import fault_irq_pkg::*;

  // Register map, one byte per offset
  //   0x00 summary: b0 top group, b1 buck group, read only
  //   0x01 top bits: b0 undervoltage, b1 warn1, b2 warn2, b3 shutdown
  //   0x02 top masks, one per top bit, 1 means masked
  //   0x03 buck bits, one per output fault
  //   0x04 buck masks, one per output fault
  //   0x05 control: b0 mask gating mode, b1 forced monitor
  //   0x06 status: b0 any pin, b1 active, b2 dormant, b3 hysteresis
  //   Other offsets read as zero and drop writes

  // Limits a user must know
  //   Comparator inputs are trusted as already filtered
  //   Thermal events are only seen while the monitor runs
  //   Register writes are lost while every enable pin is low
  //   Only the fields listed above are kept here

  // Address match for one register offset
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
    return addr == off;
  endfunction

  // Power state machine
  //   SHUTDOWN: no enable pin, registers held at defaults
  //   ACTIVE:   outputs follow their enables
  //   DORMANT:  after undervoltage, outputs off until supply recovers
  typedef enum logic [1:0] {SHUTDOWN, ACTIVE, DORMANT} pwr_e;
  pwr_e pwr, next_pwr;

  // Registers
  // Interrupt bits and masks are sized by the package counts; the
  // upper register bits read as zero.
  logic [NUM_TOP-1:0]  top_int;        // Top group sticky bits
  logic [NUM_TOP-1:0]  top_mask;       // Top group masks
  logic [NUM_BUCK-1:0] buck_int;       // Buck group sticky bits
  logic [NUM_BUCK-1:0] buck_mask;      // Buck group masks
  logic                mask_mode;      // Mask gating select
  logic                force_thermal_monitor; // Forced monitor bit
  logic                hyst_hold;      // Hot-reading hysteresis latch
  logic [NUM_TOP-1:0]  top_cond_q;     // Previous top conditions
  logic [NUM_BUCK-1:0] buck_cond_q;    // Previous buck conditions
  logic                defaults_held;  // Detection defaults latched

  // Enables and supply gating
  // All enables low or a power-on reset returns every register to its
  // default through shut_rst.
  wire any_pin   = serial_enable_pin_i | (|output_enable_pin_i);
  wire por_reset = ~resetn_i | sys_below_por_i; // R3
  wire shut_rst  = por_reset | ~any_pin;        // R17
  wire any_out   = |(output_enable_pin_i | output_enable_bit_i);

  // R20
  assign logic_supply_en_o = any_pin & ~sys_below_por_i;
  assign serial_if_en_o    = logic_supply_en_o;

  // Faults that take outputs down at once
  wire uv_fault  = sys_below_fall_i;           // R19
  wire cfg_reset = uv_fault | thermal_shutdown_i; // R5 R19
  assign config_reset_o = cfg_reset;

  // Outputs off while dormant or in fault
  // Gated combinationally so a fault takes outputs down in the same
  // cycle, without waiting for the state register.
  assign regulator_on_o = (pwr == ACTIVE && !cfg_reset) ?
                          (output_enable_pin_i | output_enable_bit_i) :
                          '0; // R1 R5

  // Thermal monitor activity
  assign thermal_monitor_on_o = any_out | force_thermal_monitor |
                                hyst_hold; // R6

  // Event conditions; thermal ones only while monitoring
  // Edges are taken against the previous cycle's conditions.
  wire [NUM_TOP-1:0] top_cond = {
    thermal_shutdown_i & thermal_monitor_on_o,
    temp_above_warn2_i & thermal_monitor_on_o,
    temp_above_warn1_i & thermal_monitor_on_o,
    uv_fault};                                  // R4
  wire [NUM_TOP-1:0]  top_edge  = top_cond & ~top_cond_q;    // R10
  wire [NUM_BUCK-1:0] buck_edge = buck_fault_i & ~buck_cond_q; // R10

  // Mode one blocks masked events at the bit
  wire [NUM_TOP-1:0]  top_set  = mask_mode ? (top_edge & ~top_mask)
                                           : top_edge;   // R15 R16
  wire [NUM_BUCK-1:0] buck_set = mask_mode ? (buck_edge & ~buck_mask)
                                           : buck_edge;  // R15 R16

  // Read strobes for clear-on-read
  wire rd_top  = reg_rd_i && addr_hit(reg_addr_i, ADDR_TOP_INT);  // R11
  wire rd_buck = reg_rd_i && addr_hit(reg_addr_i, ADDR_BUCK_INT); // R11
  wire wr_en   = reg_wr_i;
  // Write strobes, one per writable register
  wire wr_top_mask  = wr_en && addr_hit(reg_addr_i, ADDR_TOP_MASK);
  wire wr_buck_mask = wr_en && addr_hit(reg_addr_i, ADDR_BUCK_MASK);
  wire wr_ctrl      = wr_en && addr_hit(reg_addr_i, ADDR_CTRL);

  // Summary flags from unmasked bits only
  // Computed live, so a group flag drops as soon as its bits are read
  // or masked; nothing extra to clear.
  wire [NUM_TOP-1:0]  top_unm  = top_int & ~top_mask;   // R15
  wire [NUM_BUCK-1:0] buck_unm = buck_int & ~buck_mask;
  wire [7:0] summary = {6'h00, |buck_unm, |top_unm};     // R9 R21

  // Interrupt line pulled low while any unmasked bit stands
  wire irq_active = (|top_unm) | (|buck_unm);    // R7 R12 R13 R14
  assign irq_out_n_o    = 1'b0;
  assign irq_out_n_oe_o = irq_active;            // R7

  // Power state transitions
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      SHUTDOWN: if (any_pin) begin
        next_pwr = ACTIVE;
      end
      ACTIVE:   if (uv_fault) begin
        next_pwr = DORMANT; // R1
      end
      DORMANT:  if (sys_above_rise_i && !uv_fault) begin
        next_pwr = ACTIVE;  // R1
      end
    endcase
  end

  // State register; shutdown and power-on reset return to defaults
  always_ff @(posedge clk_i) begin
    if (shut_rst) begin
      pwr <= SHUTDOWN;                           // R3 R17
    end else if (ce_i) begin
      pwr <= next_pwr;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk_i) begin
    if (shut_rst) begin
      top_mask              <= TOP_MASK_RST[NUM_TOP-1:0];   // R14
      buck_mask             <= BUCK_MASK_RST[NUM_BUCK-1:0]; // R14
      mask_mode             <= CTRL_RST[CTRL_MASK_MODE];
      force_thermal_monitor <= CTRL_RST[CTRL_FORCE_MON];
    end else if (ce_i) begin
      if (wr_top_mask) begin
        top_mask <= reg_wdata_i[NUM_TOP-1:0];
      end
      if (wr_buck_mask) begin
        buck_mask <= reg_wdata_i[NUM_BUCK-1:0];
      end
      if (wr_ctrl) begin
        mask_mode             <= reg_wdata_i[CTRL_MASK_MODE];
        force_thermal_monitor <= reg_wdata_i[CTRL_FORCE_MON];
      end
    end
  end

  // Hazard: a read and a new edge can meet in one cycle. The clear
  // takes the old bits only and the fresh edge is OR'ed in after, so
  // an event caught during the read sequence keeps the line low.
  // Edge history runs even while bits are masked, so lifting a mask
  // never fakes an edge from a condition that merely persists.
  // Sticky bits: set wins over clear-on-read
  always_ff @(posedge clk_i) begin
    if (shut_rst) begin
      top_int     <= '0;
      buck_int    <= '0;
      top_cond_q  <= '0;
      buck_cond_q <= '0;
    end else if (ce_i) begin
      top_cond_q  <= top_cond;
      buck_cond_q <= buck_fault_i;
      top_int     <= (rd_top  ? '0 : top_int)  | top_set;  // R11 R12
      buck_int    <= (rd_buck ? '0 : buck_int) | buck_set; // R11 R12
    end
  end

  // Thermal hysteresis latch
  // Set by a warn1 reading while monitoring, cleared at the low point;
  // keeps the monitor running between the two temperatures.
  always_ff @(posedge clk_i) begin
    if (shut_rst) begin
      hyst_hold <= 1'b0;
    end else if (ce_i) begin
      if (thermal_monitor_on_o && temp_above_warn1_i) begin
        hyst_hold <= 1'b1;                       // R6
      end else if (temp_at_or_below_hyst_i) begin
        hyst_hold <= 1'b0;                       // R6
      end
    end
  end

  // Detection defaults loaded on the first enable, then held
  // Detection results are taken once per exit from shutdown; later
  // changes on the detection inputs are ignored until all pins drop or a power-on reset.
  always_ff @(posedge clk_i) begin
    if (shut_rst) begin
      defaults_held            <= 1'b0;          // R18
      target_voltage_code_o    <= 8'h00;
      voltage_range_sel_o      <= 2'h0;
      peak_current_limit_sel_o <= 2'h0;
      switch_freq_sel_o        <= 2'h0;
    end else if (ce_i && !defaults_held) begin
      defaults_held            <= 1'b1;          // R18
      target_voltage_code_o    <= det_voltage_code_i;
      voltage_range_sel_o      <= det_range_i;
      peak_current_limit_sel_o <= det_ilim_i;
      switch_freq_sel_o        <= det_freq_i;
    end
  end

  // Read data, captured with the read strobe
  // The answer stands until the next read; reading a group clears it
  // in the same edge, so the bits returned are those before the clear.
  always_ff @(posedge clk_i) begin
    if (shut_rst) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_SRC_SUMMARY: reg_rdata_o <= summary;        // R8
        ADDR_TOP_INT:     reg_rdata_o <= 8'(top_int);
        ADDR_TOP_MASK:    reg_rdata_o <= 8'(top_mask);
        ADDR_BUCK_INT:    reg_rdata_o <= 8'(buck_int);
        ADDR_BUCK_MASK:   reg_rdata_o <= 8'(buck_mask);
        ADDR_CTRL:        reg_rdata_o <= {6'h00, force_thermal_monitor,
                                          mask_mode};
        ADDR_STATUS:      reg_rdata_o <= {4'h0, hyst_hold,
                                          pwr == DORMANT,
                                          pwr == ACTIVE, any_pin};
        default:          reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> src/fault_irq_pkg.sv
// Purpose: Shared constants for the fault, interrupt and reset logic
// Assumes: Single 200 MHz clock domain
// Notes:   Register word offsets and reset values are named once here
package fault_irq_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_SRC_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_TOP_INT     = 8'h01;
  localparam logic [7:0] ADDR_TOP_MASK    = 8'h02;
  localparam logic [7:0] ADDR_BUCK_INT    = 8'h03;
  localparam logic [7:0] ADDR_BUCK_MASK   = 8'h04;
  localparam logic [7:0] ADDR_CTRL        = 8'h05;
  localparam logic [7:0] ADDR_STATUS      = 8'h06;
  // Top interrupt bit positions
  localparam int UV_BIT   = 0;
  localparam int TW1_BIT  = 1;
  localparam int TW2_BIT  = 2;
  localparam int TSD_BIT  = 3;
  // Group sizes: top flag count and buck count (per output fault flags)
  localparam int NUM_TOP  = 4;
  localparam int NUM_BUCK = 2;
  // Control bit positions
  localparam int CTRL_MASK_MODE = 0;
  localparam int CTRL_FORCE_MON = 1;
  // Summary bit positions
  localparam int SUM_TOP  = 0;
  localparam int SUM_BUCK = 1;
  // Reset values: everything masked except the undervoltage flag
  localparam logic [7:0] TOP_MASK_RST  = 8'h0E;
  localparam logic [7:0] BUCK_MASK_RST = 8'h03;
  localparam logic [7:0] CTRL_RST      = 8'h00;
endpackage

// >>> tb/fault_interrupt_and_reset_logic_tb_top.sv
// Purpose: Self-checking bench for the fault and interrupt block
// Assumes: Inputs change at the falling edge of a 200 MHz clock
// Notes:   Reads are checked by a monitor against queued notes
`timescale 1ns/10ps
`default_nettype none
module fault_interrupt_and_reset_logic_tb_top;
  import fault_irq_pkg::*;
  logic        clk, rstn, rise, fall, por, warn1, warn2, hyst, tsd, spin;
  logic [1:0]  fault, oepin, rng, ilim, freq, ron, trng, tilim, tfreq;
  logic [7:0]  vcode, rdata, tgt, addr, wdata;
  logic        rd, wr, lsup, sif, mon, cfgrst, pin_n, oe, wire_n, rd_d;
  logic [13:0] dflt; // First detection results
  int          error_cnt = 0;
  int          checks = 0;
  // 5 ns clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  fault_interrupt_and_reset_logic dut (.clk_i(clk), .resetn_i(rstn),
    .ce_i(1'b1), .sys_above_rise_i(rise), .sys_below_fall_i(fall),
    .sys_below_por_i(por), .temp_above_warn1_i(warn1),
    .temp_above_warn2_i(warn2), .temp_at_or_below_hyst_i(hyst),
    .thermal_shutdown_i(tsd), .buck_fault_i(fault),
    .serial_enable_pin_i(spin), .output_enable_pin_i(oepin),
    .output_enable_bit_i(2'b00), .det_voltage_code_i(vcode),
    .det_range_i(rng), .det_ilim_i(ilim), .det_freq_i(freq),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .logic_supply_en_o(lsup), .serial_if_en_o(sif),
    .regulator_on_o(ron), .thermal_monitor_on_o(mon),
    .config_reset_o(cfgrst), .target_voltage_code_o(tgt),
    .voltage_range_sel_o(trng), .peak_current_limit_sel_o(tilim),
    .switch_freq_sel_o(tfreq), .irq_out_n_o(pin_n), .irq_out_n_oe_o(oe));
  host_model host (.clk_i(clk), .irq_oe_i(oe), .rd_o(rd), .wr_o(wr),
    .addr_o(addr), .wdata_o(wdata), .irq_wire_o(wire_n));
  // Compare one value
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Wait falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Read answers land one cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) chk("rdata", rdata, host.exp_q.pop_front());
  end
  // Tests take about a hundred cycles; allow far more
  initial begin
    #20000;
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(49515));
    dflt = 14'($urandom);
    {vcode, rng, ilim, freq} = dflt;
    {fall, por, warn1, warn2, hyst, tsd, fault, oepin} = 10'h000;
    {rstn, rise, spin} = 3'b011;
    cyc(10);
    rstn = 1'b1;
    cyc(3);
    chk("defaults", tgt, vcode);
    chk("fields", {2'b00, trng, tilim, tfreq}, {2'b00, rng, ilim, freq});
    host.rd(ADDR_TOP_MASK, TOP_MASK_RST);
    host.rd(ADDR_BUCK_MASK, BUCK_MASK_RST);
    host.rd(ADDR_CTRL, CTRL_RST);
    host.rd(8'h3C, 8'h00);
    $display("test reset values done");
    {rise, fall} = 2'b01;
    cyc(2);
    chk("irq wire", {7'h00, wire_n}, 8'h00);
    host.rd(ADDR_SRC_SUMMARY, 8'h01);
    host.rd(ADDR_STATUS, 8'h05);
    host.rd(ADDR_TOP_INT, 8'h01);
    host.rd(ADDR_TOP_INT, 8'h00);
    host.rd(ADDR_SRC_SUMMARY, 8'h00);
    chk("irq wire", {7'h00, wire_n}, 8'h01);
    {rise, fall, fault} = 4'b1001;
    cyc(2);
    host.rd(ADDR_SRC_SUMMARY, 8'h00);
    host.rd(ADDR_BUCK_INT, 8'h01);
    host.wr(ADDR_CTRL, 8'h01);
    fault = 2'b11;
    cyc(2);
    host.rd(ADDR_BUCK_INT, 8'h00);
    host.wr(ADDR_BUCK_MASK, 8'h00);
    fault = 2'b00;
    cyc(2);
    fault = 2'b10;
    cyc(2);
    chk("irq wire", {7'h00, wire_n}, 8'h00);
    host.wr(ADDR_BUCK_MASK, BUCK_MASK_RST);
    chk("irq wire", {7'h00, wire_n}, 8'h01);
    host.rd(ADDR_BUCK_INT, 8'h02);
    $display("test interrupt flow done");
    host.wr(ADDR_CTRL, 8'h02);
    cyc(2);
    chk("monitor", {7'h00, mon}, 8'h01);
    warn1 = 1'b1;
    cyc(2);
    warn2 = 1'b1;
    cyc(2);
    host.rd(ADDR_TOP_INT, 8'h06);
    host.wr(ADDR_CTRL, 8'h00);
    cyc(2);
    chk("monitor", {7'h00, mon}, 8'h01);
    {warn1, warn2, hyst} = 3'b001;
    cyc(2);
    chk("monitor", {7'h00, mon}, 8'h00);
    oepin = 2'b01;
    cyc(4);
    chk("outputs on", {6'h00, ron}, 8'h01);
    {hyst, tsd} = 2'b01;
    cyc(1);
    chk("outputs off", {6'h00, ron}, 8'h00);
    chk("config reset", {7'h00, cfgrst}, 8'h01);
    host.rd(ADDR_TOP_INT, 8'h08);
    $display("test thermal done");
    {tsd, oepin} = 3'b000;
    host.wr(ADDR_TOP_MASK, 8'h00);
    {vcode, rng, ilim, freq} = ~dflt;
    cyc(2);
    chk("held", tgt, dflt[13:6]);
    spin = 1'b0;
    cyc(2);
    chk("supply", {6'h00, lsup, sif}, 8'h00);
    spin = 1'b1;
    cyc(3);
    chk("defaults", tgt, vcode);
    host.rd(ADDR_TOP_MASK, TOP_MASK_RST);
    host.wr(ADDR_CTRL, 8'h02);
    por = 1'b1;
    cyc(1);
    chk("supply", {6'h00, lsup, sif}, 8'h00);
    por = 1'b0;
    cyc(2);
    host.rd(ADDR_CTRL, CTRL_RST);
    $display("test shutdown done");
    results();
  end
endmodule
`default_nettype wire

// >>> tb/fault_irq_props.sv
// Purpose: Port-level checks for the fault and interrupt block
// Assumes: One clock domain; bench keeps ce_i high
// Notes:   Attached to every instance by the bind after the module
`timescale 1ns/10ps
`default_nettype none
module fault_irq_props import fault_irq_pkg::*; #(
  parameter int NUM_OUT = 2
) (
  // Clock and reset
  input wire logic               clk_i,
  input wire logic               resetn_i,
  // Watched inputs
  input wire logic               ce_i,
  input wire logic               sys_above_rise_i,
  input wire logic               sys_below_fall_i,
  input wire logic               sys_below_por_i,
  input wire logic               thermal_shutdown_i,
  input wire logic               serial_enable_pin_i,
  input wire logic [NUM_OUT-1:0] output_enable_pin_i,
  input wire logic               reg_rd_i,
  input wire logic               reg_wr_i,
  input wire logic [7:0]         reg_addr_i,
  // Watched outputs
  input wire logic [7:0]         reg_rdata_o,
  input wire logic               logic_supply_en_o,
  input wire logic               serial_if_en_o,
  input wire logic [NUM_OUT-1:0] regulator_on_o,
  input wire logic               thermal_monitor_on_o,
  input wire logic               config_reset_o,
  input wire logic [7:0]         target_voltage_code_o,
  input wire logic               irq_out_n_o,
  input wire logic               irq_out_n_oe_o
);
  // Any enable pin high
  wire logic pin_up = serial_enable_pin_i | (|output_enable_pin_i);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_PIN_SINKS_ONLY: assert property (irq_out_n_o == 1'b0)
    else $error("interrupt pin drives high");
  AST_SUPPLY_FOLLOWS_PINS: assert property (logic_supply_en_o ==
    (pin_up && !sys_below_por_i) && serial_if_en_o == logic_supply_en_o)
    else $error("supply enable does not follow enable pins");
  AST_TSD_OFF: assert property (thermal_shutdown_i |->
    regulator_on_o == '0 && config_reset_o)
    else $error("outputs on during thermal shutdown");
  AST_UV_OFF: assert property (sys_below_fall_i |-> regulator_on_o == '0)
    else $error("outputs on below falling threshold");
  AST_DORMANT: assert property ($past(sys_below_fall_i)
    && !sys_above_rise_i |-> regulator_on_o == '0)
    else $error("outputs left dormant state early");
  AST_MON_WITH_OUTPUT: assert property (|regulator_on_o
    |-> thermal_monitor_on_o)
    else $error("thermal monitor off with output on");
  AST_UNMAPPED_ZERO: assert property (reg_rd_i && ce_i && pin_up &&
    !sys_below_por_i && reg_addr_i > ADDR_STATUS |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_IRQ_HOLD: assert property ($fell(irq_out_n_oe_o) |->
    $past(reg_rd_i || reg_wr_i || sys_below_por_i || !pin_up))
    else $error("interrupt released without read or mask");
  AST_DEFAULTS_HOLD: assert property ((pin_up && !sys_below_por_i)[*4]
    |=> $stable(target_voltage_code_o))
    else $error("latched default changed while enabled");
  // Main scenarios seen
  cover property ($fell(irq_out_n_oe_o));
  cover property (thermal_shutdown_i && !config_reset_o == 1'b0);
  cover property (reg_rd_i && reg_addr_i > ADDR_STATUS);
endmodule
bind fault_interrupt_and_reset_logic fault_irq_props #(.NUM_OUT(NUM_OUT))
  props (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .sys_above_rise_i(sys_above_rise_i), .sys_below_fall_i(sys_below_fall_i),
  .sys_below_por_i(sys_below_por_i), .thermal_shutdown_i(thermal_shutdown_i),
  .serial_enable_pin_i(serial_enable_pin_i), .reg_addr_i(reg_addr_i),
  .output_enable_pin_i(output_enable_pin_i), .reg_rd_i(reg_rd_i),
  .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
  .logic_supply_en_o(logic_supply_en_o), .serial_if_en_o(serial_if_en_o),
  .regulator_on_o(regulator_on_o), .config_reset_o(config_reset_o),
  .thermal_monitor_on_o(thermal_monitor_on_o), .irq_out_n_o(irq_out_n_o),
  .target_voltage_code_o(target_voltage_code_o),
  .irq_out_n_oe_o(irq_out_n_oe_o));
`default_nettype wire

// >>> tb/host_model.sv
// Purpose: Host side: register strobes and the pulled-up interrupt wire
// Assumes: Requests are one-cycle pulses taken at the rising edge
// Notes:   Expected read data is queued for the bench monitor
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock and interrupt sink enable
  input  wire logic       clk_i,
  input  wire logic       irq_oe_i,
  // Register strobes
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  // Resolved interrupt wire
  output logic            irq_wire_o
);
  logic [7:0] exp_q [$]; // Expected read data, oldest first
  // Pull-up wins unless the device sinks the line
  assign irq_wire_o = irq_oe_i ? 1'b0 : 1'b1;
  // Idle strobes
  initial begin
    {rd_o, wr_o, addr_o, wdata_o} = 18'h00000;
  end
  // One read; address goes stale once released
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b1, a};
    exp_q.push_back(e);
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b0, ~a};
  endtask
  // One write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire
